//--- hw/core_fix.sv
// Exception, low-power and bit-manipulation unit of an 8-bit core.
// Assumes the sequencer issues one operation per op_valid pulse and waits on busy.
`timescale 1ns/100ps
module core_fix
#(
  parameter int ISR_BODY_CYCLES = 8
)(
  input  wire logic                     ref_clk,       // Core clock
  input  wire logic                     rstn,          // Sync reset, low
  input  wire logic                     op_valid,      // Operation strobe
  input  wire core_fix_pkg::op_t        op,            // Operation code
  input  wire core_fix_pkg::addr_mode_t addr_mode,     // Addressing mode
  input  wire logic [7:0]               acc,           // Accumulator
  input  wire logic [7:0]               mem_operand,   // Memory operand
  input  wire logic [2:0]               bit_sel,       // Bit number
  input  wire logic [7:0]               rd_data,       // Read data
  input  wire logic                     irq_pin,       // External request
  input  wire logic                     timer_irq,     // Timer interrupt
  input  wire logic                     async_irq,     // Serial async irq
  input  wire logic                     sync_irq,      // Serial sync irq
  output logic                          carry,         // Carry flag
  output logic                          int_mask,      // Interrupt mask
  output logic                          busy,          // Operation running
  output logic                          illegal_op,    // Bad addressing
  output logic                          rd_req,        // Byte read strobe
  output logic                          wr_req,        // Byte write strobe
  output logic [7:0]                    wr_data,       // Write data
  output logic                          stopped,       // In stop mode
  output logic                          waiting,       // In wait mode
  output logic                          irq_take       // Interrupt accepted
);
  import core_fix_pkg::*;

  // ************************************************
  // Pin synchroniser
  // ************************************************
  logic [2:0] irq_sync_q, irq_sync_d;
  logic       irq_lvl_q, irq_lvl_d;
  logic       irq_lvl;
  always_comb
  begin
    irq_sync_d = {irq_sync_q[1:0], irq_pin};
    // A change counts only once the two late stages agree; a glitch leaves the level alone
    irq_lvl_d  = (irq_sync_q[1] == irq_sync_q[2]) ? irq_sync_q[2] : irq_lvl_q;
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      irq_sync_q <= 3'h0;
      irq_lvl_q  <= 1'b0;
    end
    else
    begin
      irq_sync_q <= irq_sync_d;
      irq_lvl_q  <= irq_lvl_d;
    end
  end
  assign irq_lvl = irq_lvl_q;

  // ************************************************
  // Core state
  // ************************************************
  localparam logic [7:0] SPACING = 8'(ISR_FIXED_CYCLES + ISR_BODY_CYCLES);
  core_state_t st_q, st_d;
  logic       carry_q, carry_d, mask_q, mask_d, ill_q, ill_d;
  logic       rd_q, rd_d, wr_q, wr_d, take_q, take_d;
  logic [7:0] wdat_q, wdat_d, space_q, space_d;
  logic [2:0] bsel_q, bsel_d;
  logic       set_q, set_d;
  logic       busy_q, busy_d, stop_q, stop_d, wait_q, wait_d;
  logic       periph_irq;
  assign periph_irq = timer_irq | async_irq | sync_irq;

  always_comb
  begin
    st_d    = st_q;
    carry_d = carry_q;
    mask_d  = mask_q;
    ill_d   = 1'b0;
    rd_d    = 1'b0;
    wr_d    = 1'b0;
    take_d  = 1'b0;
    wdat_d  = wdat_q;
    bsel_d  = bsel_q;
    set_d   = set_q;
    space_d = (space_q != 8'h00) ? space_q - 8'h01 : space_q;
    case (st_q)
      ST_RUN:
      begin
        if (op_valid)
        begin
          case (op)
            // [RL1] Magnitude compare
            OP_SUB:  carry_d = (mem_operand > acc);
            OP_BIT_SET, OP_BIT_CLR:
            begin
              // [RL6] Direct only
              if (addr_mode != ADDR_DIRECT)
                ill_d = 1'b1;
              else
              begin
                st_d   = ST_RMW_RD;
                rd_d   = 1'b1;
                bsel_d = bit_sel;
                set_d  = (op == OP_BIT_SET);
              end
            end
            // [RL3] Stop clears mask
            OP_STOP:
            begin
              mask_d = 1'b0;
              st_d   = ST_STOP;
            end
            // [RL9] Wait clears mask
            OP_WAIT:
            begin
              mask_d = 1'b0;
              st_d   = ST_WAIT;
            end
            OP_RET_INT: mask_d = 1'b0;
            default: ;
          endcase
        end
        // [RL2] Spacing between taken requests
        else if (irq_lvl && !mask_q && space_q == 8'h00)
        begin
          take_d  = 1'b1;
          mask_d  = 1'b1;
          // Load one less: the cycle of the take itself counts toward the spacing
          space_d = SPACING - 8'h01;
        end
      end
      ST_RMW_RD:
        st_d = ST_RMW_WR;
      // [RL5] Whole byte written back; [RL7] unknown bits pass through
      ST_RMW_WR:
      begin
        wr_d   = 1'b1;
        wdat_d = set_q ? (rd_data | (8'h01 << bsel_q))
                       : (rd_data & ~(8'h01 << bsel_q));
        st_d   = ST_RUN;
      end
      // [RL4] External request ends stop
      ST_STOP:
        if (irq_lvl)
          st_d = ST_RUN;
      // [RL10] Any interrupt ends wait
      ST_WAIT:
        if (irq_lvl || periph_irq)
          st_d = ST_RUN;
      default:
        st_d = ST_RUN;
    endcase
    // Status outputs decoded ahead of the register so the pins come from flops
    busy_d = (st_d != ST_RUN);
    stop_d = (st_d == ST_STOP);
    wait_d = (st_d == ST_WAIT);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      st_q    <= ST_RUN;
      carry_q <= CARRY_RESET;
      mask_q  <= MASK_RESET;
      ill_q   <= 1'b0;
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
      take_q  <= 1'b0;
      wdat_q  <= 8'h00;
      bsel_q  <= 3'h0;
      set_q   <= 1'b0;
      space_q <= SPACING_RESET;
      busy_q  <= 1'b0;
      stop_q  <= 1'b0;
      wait_q  <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      carry_q <= carry_d;
      mask_q  <= mask_d;
      ill_q   <= ill_d;
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      take_q  <= take_d;
      wdat_q  <= wdat_d;
      bsel_q  <= bsel_d;
      set_q   <= set_d;
      space_q <= space_d;
      busy_q  <= busy_d;
      stop_q  <= stop_d;
      wait_q  <= wait_d;
    end
  end

  assign carry      = carry_q;
  assign int_mask   = mask_q;
  assign busy       = busy_q;
  assign illegal_op = ill_q;
  assign rd_req     = rd_q;
  assign wr_req     = wr_q;
  assign wr_data    = wdat_q;
  assign stopped    = stop_q;
  assign waiting    = wait_q;
  assign irq_take   = take_q;

  // ************************************************
  // Checks
  // ************************************************
  chk_sub_carry: assert property (@(posedge ref_clk) disable iff (!rstn) // [RL1]
    (st_q == ST_RUN && op_valid && op == OP_SUB) |=> carry == $past(mem_operand > acc))
    else $error("carry wrong after subtract");
  // Cycles since the last accepted request, saturating; the spacing is too long to unroll
  logic [7:0] gap_q, gap_d;
  always_comb
  begin
    gap_d = gap_q;
    if (take_q)
      gap_d = 8'h01;
    else if (gap_q != 8'hff)
      gap_d = gap_q + 8'h01;
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      gap_q <= GAP_RESET;
    else
      gap_q <= gap_d;
  end
  chk_irq_spacing: assert property (@(posedge ref_clk) disable iff (!rstn) // [RL2]
    irq_take |-> gap_q >= SPACING)
    else $error("interrupts too close");
  chk_stop_mask: assert property (@(posedge ref_clk) disable iff (!rstn) // [RL3]
    (st_q == ST_RUN && op_valid && op == OP_STOP) |=> (!int_mask && stopped))
    else $error("stop did not clear mask");
  chk_stop_wake: assert property (@(posedge ref_clk) disable iff (!rstn) // [RL4]
    (stopped && irq_lvl) |=> !stopped)
    else $error("stop not released");
  chk_rmw_seq: assert property (@(posedge ref_clk) disable iff (!rstn) // [RL5]
    rd_req |=> ##1 wr_req)
    else $error("read not followed by write");
  chk_direct_only: assert property (@(posedge ref_clk) disable iff (!rstn) // [RL6]
    (st_q == ST_RUN && op_valid && (op == OP_BIT_SET || op == OP_BIT_CLR)
     && addr_mode != ADDR_DIRECT) |=> (illegal_op && !rd_req))
    else $error("non-direct bit op accepted");
  chk_rmw_bit: assert property (@(posedge ref_clk) disable iff (!rstn) // [RL7]
    wr_req |-> wr_data[bsel_q] == set_q)
    else $error("selected bit not written");
  chk_wait_mask: assert property (@(posedge ref_clk) disable iff (!rstn) // [RL9]
    (st_q == ST_RUN && op_valid && op == OP_WAIT) |=> (!int_mask && waiting))
    else $error("wait did not clear mask");
  chk_wait_wake: assert property (@(posedge ref_clk) disable iff (!rstn) // [RL10]
    (waiting && periph_irq) |=> !waiting)
    else $error("wait not released");
  cov_stop_wake: cover property (@(posedge ref_clk) stopped ##1 !stopped);
  cov_wait_wake: cover property (@(posedge ref_clk) waiting ##1 !waiting);
  cov_rmw: cover property (@(posedge ref_clk) wr_req);
  cov_take: cover property (@(posedge ref_clk) irq_take);
endmodule // core_fix

//--- hw/core_fix_pkg.sv
// Constants and types shared by the core exception/low-power unit.
// Assumes one 100 MHz clock and a synchronous active-low reset.
//
// Overview of operation
// [RL1] Subtract sets carry when memory operand exceeds accumulator, else clears it.
// [RL2] Interrupt spacing is 19 cycles plus service routine body cycles.
// [RL3] Stop instruction clears the interrupt mask bit.
// [RL4] In stop mode an external interrupt request resumes the core.
// [RL5] Bit set and bit clear read whole byte, modify bit, write byte back.
// [RL6] Bit set and bit clear accept direct addressing only.
// [RL7] Write-only registers read undefined, so the written-back byte is undefined.
// [RL8] Software must not apply bit set or clear to write-only registers.
// [RL9] Wait instruction clears the interrupt mask bit on entering wait.
// [RL10] Wait mode resumes on external or any internal peripheral interrupt.
package core_fix_pkg;
  // ************************************************
  // Operations and modes
  // ************************************************
  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_SUB   = 3'b001,
    OP_BIT_SET = 3'b010,
    OP_BIT_CLR = 3'b011,
    OP_STOP    = 3'b100,
    OP_WAIT    = 3'b101,
    OP_RET_INT = 3'b110
  } op_t;

  typedef enum logic [1:0] {
    ADDR_DIRECT  = 2'b00,
    ADDR_INDEXED = 2'b01,
    ADDR_EXTEND  = 2'b10,
    ADDR_IMMED   = 2'b11
  } addr_mode_t;

  typedef enum logic [2:0] {
    ST_RUN    = 3'b000,
    ST_RMW_RD = 3'b001,
    ST_RMW_WR = 3'b010,
    ST_STOP   = 3'b011,
    ST_WAIT   = 3'b100
  } core_state_t;

  // ************************************************
  // Reset values and counts
  // ************************************************
  localparam logic       MASK_RESET       = 1'b1;
  localparam logic       CARRY_RESET      = 1'b0;
  localparam int         ISR_FIXED_CYCLES = 19;
  localparam logic [7:0] SPACING_RESET    = 8'h00;
  // Gap counter starts saturated so the first request after reset is never flagged
  localparam logic [7:0] GAP_RESET        = 8'hff;
endpackage

//--- test/cpu_interrupt_lowpower_fixes_test.sv
// Self-checking bench for the core exception and low-power unit.
// Assumes the far-side model drives rd_data and irq_pin.
`timescale 1ns/100ps
module cpu_interrupt_lowpower_fixes_test;
  import core_fix_pkg::*;
  localparam int BODY = 4;
  localparam int SPACE = ISR_FIXED_CYCLES + BODY;
  typedef struct {op_t o; logic [7:0] a, m; logic [2:0] b; logic [7:0] rd, e;} row_t;
  logic ref_clk = 1'b0, rstn = 1'b0, op_valid = 1'b0, irq_req = 1'b0;
  op_t op = OP_NONE;
  addr_mode_t addr_mode = ADDR_DIRECT;
  logic [7:0] acc = 8'h00, mem_operand = 8'h00, rd_byte = 8'h00, rd_data, wr_data;
  logic [2:0] bit_sel = 3'h0;
  logic [3:0] src = 4'h0;
  logic irq_pin, carry, int_mask, busy, illegal_op, rd_req, wr_req, stopped, waiting, irq_take;
  wire [2:0] ev = {~waiting, irq_take, wr_req};
  int err_total = 0, check_count = 0, cyc = 0, t0, n;
  row_t rows[6] = '{'{OP_SUB, 8'h10, 8'h20, 3'h0, 8'h00, 8'h01},
    '{OP_SUB, 8'h20, 8'h10, 3'h0, 8'h00, 8'h00}, '{OP_SUB, 8'h33, 8'h33, 3'h0, 8'h00, 8'h00},
    '{OP_BIT_SET, 8'h00, 8'h00, 3'h7, 8'h0f, 8'h8f},
    '{OP_BIT_CLR, 8'h00, 8'h00, 3'h0, 8'h0f, 8'h0e},
    '{OP_BIT_SET, 8'h00, 8'h00, 3'h3, 8'hff, 8'hff}};
  core_fix #(.ISR_BODY_CYCLES(BODY)) DUT (.ref_clk(ref_clk), .rstn(rstn), .op_valid(op_valid),
    .op(op), .addr_mode(addr_mode), .acc(acc), .mem_operand(mem_operand), .bit_sel(bit_sel),
    .rd_data(rd_data), .irq_pin(irq_pin), .timer_irq(src[1]), .async_irq(src[2]),
    .sync_irq(src[3]), .carry(carry), .int_mask(int_mask), .busy(busy),
    .illegal_op(illegal_op), .rd_req(rd_req), .wr_req(wr_req), .wr_data(wr_data),
    .stopped(stopped), .waiting(waiting), .irq_take(irq_take));
  irq_partner far (.ref_clk(ref_clk), .rd_req(rd_req), .irq_req(irq_req | src[0]),
    .rd_byte(rd_byte), .rd_data(rd_data), .irq_pin(irq_pin));
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  // ************************************************
  // Helpers
  // ************************************************
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bounded wait on one event line; running out ends the run
  task automatic await(input int k);
    for (n = 0; n < 200; n++)
    begin
      @(negedge ref_clk);
      if (ev[k] === 1'b1) return;
    end
    chk("timeout", 8'h01, 8'h00);
    end_sim();
  endtask
  // A spare falling edge first, so op_valid never drops and rises in one time step
  task automatic do_op(input op_t o, input addr_mode_t m);
    @(negedge ref_clk);
    op_valid = 1'b1;
    op = o;
    addr_mode = m;
    @(negedge ref_clk);
    op_valid = 1'b0;
  endtask
  // ************************************************
  // Sequence
  // ************************************************
  initial
  begin
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    chk("carry", carry, 8'h00);
    chk("mask", int_mask, 8'h01);
    chk("busy", busy, 8'h00);
    foreach (rows[i])
    begin
      {acc, mem_operand, bit_sel, rd_byte} = {rows[i].a, rows[i].m, rows[i].b, rows[i].rd};
      do_op(rows[i].o, ADDR_DIRECT);
      if (rows[i].o == OP_SUB)
        chk("carry", carry, rows[i].e);
      else
      begin
        chk("rd_req", rd_req, 8'h01);
        chk("busy", busy, 8'h01);
        await(0);
        chk("wr_data", wr_data, rows[i].e);
      end
    end
    // Every non-direct mode: bit set on extended, bit clear on indexed and immediate
    for (int m = 1; m < 4; m++)
    begin
      do_op((m == 2) ? OP_BIT_SET : OP_BIT_CLR, addr_mode_t'(m));
      chk("illegal", illegal_op, 8'h01);
      chk("rd_req", rd_req, 8'h00);
    end
    do_op(OP_STOP, ADDR_DIRECT);
    chk("mask", int_mask, 8'h00);
    chk("stopped", stopped, 8'h01);
    irq_req = 1'b1;
    await(1);
    chk("stopped", stopped, 8'h00);
    chk("mask", int_mask, 8'h01);
    t0 = cyc;
    do_op(OP_RET_INT, ADDR_DIRECT);
    await(1);
    chk("spacing", 8'((cyc - t0) >= SPACE), 8'h01);
    chk("spacing", 8'((cyc - t0) <= SPACE + 4), 8'h01);
    irq_req = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      repeat (SPACE) @(negedge ref_clk);
      do_op(OP_WAIT, ADDR_DIRECT);
      chk("mask", int_mask, 8'h00);
      chk("waiting", waiting, 8'h01);
      src = 4'(1 << k);
      await(2);
      chk("waiting", waiting, 8'h00);
      src = 4'h0;
    end
    // Reset in mid-run from stop with carry set
    {acc, mem_operand} = {8'h00, 8'h01};
    do_op(OP_SUB, ADDR_DIRECT);
    do_op(OP_STOP, ADDR_DIRECT);
    chk("carry", carry, 8'h01);
    rstn = 1'b0;
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    chk("carry", carry, 8'h00);
    chk("mask", int_mask, 8'h01);
    chk("stopped", stopped, 8'h00);
    chk("busy", busy, 8'h00);
    end_sim();
  end
endmodule // cpu_interrupt_lowpower_fixes_test

//--- test/irq_partner.sv
// Far-side model: external interrupt source plus the memory answering byte reads.
// Assumes reads are answered on the cycle after rd_req, as the core samples them then.
`timescale 1ns/100ps
module irq_partner (
  input  wire logic       ref_clk,  // Core clock
  input  wire logic       rd_req,   // Byte read strobe
  input  wire logic       irq_req,  // Bench asks for a request
  input  wire logic [7:0] rd_byte,  // Byte the target holds
  output logic      [7:0] rd_data,  // Read data to core
  output logic            irq_pin   // External request
);
  assign irq_pin = irq_req;
  // ************************************************
  // Read answer
  // ************************************************
  // Target byte readable
  // Outside the answer cycle the bus flips so a late sample is visible
  always @(posedge ref_clk)
  begin
    rd_data <= rd_req ? rd_byte : ~rd_data;
  end
endmodule // irq_partner
